// *** src/opmode_ctrl.v ***
// operating-mode controller: stop / start-up / run / hold sequencing,
// output disable, lamps, routine gating, breakpoints, APB registers
// assumes an APB master on pclk; program address and
// cycle-end strobe arrive from the execution engine on the same clock
//
// Functional notes
// - exactly one of four modes held
// - stop suppresses all program execution
// - stop retains counters, timers, flags, image
// - stop: outputs disabled, run off, stop lit; the run lamp still blinks in stop until the blink timer runs out
// - stop toward run enters start-up routine
// - start-up routine unsupervised, may call blocks
// - start-up keeps outputs disabled
// - run lamp blinks at least three seconds
// - stop lamp lit during start-up, then dark
// - start-up completion moves to run
// - watchdog error holds stop until restart
// - watchdog restart needs cold-start routine present
// - overall reset or reload also recovers
// - run executes cyclic main routine repeatedly
// - run: timers active, image refreshed
// - run: outputs enabled, run lit, stop dark
// - three breakpoints; hit switches into hold
// - hold: run lamp blinks, stop lit
// - hold freezes execution, timers; clock runs
// - hold keeps outputs disabled
// - single step refused above two breakpoints
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "opmode_consts.vh"

module opmode_ctrl #(
  parameter NUM_BP       = 3,
  parameter BLINK_CYCLES = `CLK_HZ * `BLINK_MIN_S,
  parameter HALF_CYCLES  = `CLK_HZ / 1000 * `BLINK_HALF_MS,
  parameter [31:0] ID_VALUE = 32'h0000_0a5c
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] prog_addr,
  input  wire        cycle_end,
  output reg  [1:0]  mode_r,
  output reg         output_disable_flag,
  output reg         executing_lamp,
  output reg         halted_lamp,
  output reg         restart_startup_routine,
  output reg         cold_start_routine,
  output reg         cyclic_main_routine,
  output reg         timers_enable,
  output reg         image_refresh
);
  // ID_VALUE is arbitrary, names no maker

  localparam CW = 28;

  reg  [1:0]            mode_nxt;
  wire [NUM_BP*`BP_WIDTH-1:0] bp_all;
  wire [NUM_BP-1:0]     bp_act;
  wire [NUM_BP-1:0]     bp_hit;
  wire [NUM_BP-1:0]     bp_sel;
  reg  [15:0]           hold_addr_r;
  reg                   hit_mask_r;
  reg                   wdog_lock_r;
  reg                   cold_path_r;
  reg                   step_r;
  reg                   step_refused_r;
  reg  [CW-1:0]         blink_cnt_r;
  reg  [CW-1:0]         half_cnt_r;
  reg                   blink_ph_r;
  reg                   hit_r;
  reg  [1:0]            bp_count;
  reg                   bp_match;
  reg  [31:0]           rd_mux;
  integer               i;
  integer               k;

  wire acc    = psel & penable & pready;
  wire wr     = acc & pwrite;
  wire wr_ctl = wr & (paddr == `ADDR_CTRL);
  wire run_req   = wr_ctl & pwdata[`CTRL_RUN_REQ];
  wire stop_req  = wr_ctl & pwdata[`CTRL_STOP_REQ];
  wire step_req  = wr_ctl & pwdata[`CTRL_STEP_REQ];
  wire resume    = wr_ctl & pwdata[`CTRL_RESUME_REQ];
  wire su_done   = wr_ctl & pwdata[`CTRL_STARTUP_DONE];
  wire wdog      = wr_ctl & pwdata[`CTRL_WDOG_ERR];
  wire csr_here  = pwdata[`CTRL_CSR_PRESENT];
  wire recover   = wr_ctl & (pwdata[`CTRL_OVERALL_RST] |
                             pwdata[`CTRL_RELOAD]);
  wire blinking  = (blink_cnt_r != {CW{1'b0}});
  wire hit_masked = hit_mask_r & (prog_addr == hold_addr_r);

  // one slot per breakpoint; each decodes its own word address, so a
  // change of NUM_BP needs no edit of the write path; the read path's mapped decode stops at ADDR_BP_LAST
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g = g + 1)
    begin : bp_slot
      localparam integer SLOT_INT  = `ADDR_BP_BASE + g * `BP_STRIDE;
      localparam [11:0]  SLOT_ADDR = SLOT_INT[11:0];

      reg  [`BP_WIDTH-1:0] slot_r;
      wire                 slot_hit;

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          slot_r <= {`BP_WIDTH{1'b0}};
        else if (wr && paddr == SLOT_ADDR)
          slot_r <= {pwdata[`BP_VALID_BIT],
                     pwdata[`BP_ADDR_MSB:0]};
      end

      assign slot_hit = (slot_r[`BP_ADDR_MSB:0] == prog_addr);
      assign bp_all[g*`BP_WIDTH +: `BP_WIDTH] = slot_r;
      assign bp_act[g] = slot_r[`BP_VALID_POS];
      assign bp_hit[g] = slot_r[`BP_VALID_POS] & slot_hit;
      assign bp_sel[g] = (paddr == SLOT_ADDR);
    end
  endgenerate

  // count active breakpoints and look for a hit on the program address
  always @*
  begin
    bp_count = 2'h0;
    bp_match = 1'b0;
    for (i = 0; i < NUM_BP; i = i + 1)
    begin
      bp_count = bp_count + {1'b0, bp_act[i]};
      bp_match = bp_match | bp_hit[i];
    end
  end

  // mode sequencing
  always @*
  begin
    mode_nxt = mode_r;
    case (mode_r)
      `MODE_STOP:
      begin
        if (run_req)
        begin
          if (!wdog_lock_r)
            mode_nxt = `MODE_STARTUP;
          else if (csr_here)
            mode_nxt = `MODE_STARTUP;
        end
      end
      `MODE_STARTUP:
      begin
        if (wdog | stop_req)
          mode_nxt = `MODE_STOP;
        else if (su_done)
          mode_nxt = `MODE_RUN;
      end
      `MODE_RUN:
      begin
        if (wdog | stop_req)
          mode_nxt = `MODE_STOP;
        else if (hit_r)
          mode_nxt = `MODE_HOLD;
      end
      `MODE_HOLD:
      begin
        if (wdog | stop_req)
          mode_nxt = `MODE_STOP;
        else if (resume)
          mode_nxt = `MODE_RUN;
      end
      default:
        mode_nxt = `MODE_STOP;
    endcase
  end

  // breakpoint hit is registered; step lets one statement through
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hit_r          <= 1'b0;
      step_r         <= 1'b0;
      step_refused_r <= 1'b0;
    end
    else
    begin
      hit_r <= cyclic_main_routine & bp_match & ~step_r &
               ~hit_masked;
      // refusal stays visible until the next step request made in hold
      if (step_req & (mode_r == `MODE_HOLD))
      begin
        step_r         <= (bp_count <= `STEP_MAX_BP);
        step_refused_r <= (bp_count > `STEP_MAX_BP);
      end
      else
        step_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r      <= `MODE_STOP;
      wdog_lock_r <= 1'b0;
      cold_path_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      if (wdog & (mode_r != `MODE_STOP))
        wdog_lock_r <= 1'b1;
      else if (recover)
        wdog_lock_r <= 1'b0;
      else if (mode_r == `MODE_STOP && mode_nxt == `MODE_STARTUP)
        wdog_lock_r <= 1'b0;
      if (mode_r == `MODE_STOP && mode_nxt == `MODE_STARTUP)
        cold_path_r <= wdog_lock_r & ~recover;
    end
  end

  // the statement the engine halted on must not trip its breakpoint
  // again right after resume, or hold could never be left; the mask
  // lifts once the address has moved on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_addr_r <= 16'h0000;
      hit_mask_r  <= 1'b0;
    end
    else
    begin
      if (mode_r == `MODE_RUN && mode_nxt == `MODE_HOLD)
      begin
        hold_addr_r <= prog_addr;
        hit_mask_r  <= 1'b1;
      end
      else if (mode_r != `MODE_HOLD && prog_addr != hold_addr_r)
        hit_mask_r <= 1'b0;
    end
  end

  // blink timer: armed on start-up entry, runs out even after stop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt_r <= {CW{1'b0}};
      half_cnt_r  <= {CW{1'b0}};
      blink_ph_r  <= 1'b0;
    end
    else
    begin
      if (mode_r != `MODE_STARTUP && mode_nxt == `MODE_STARTUP)
        blink_cnt_r <= BLINK_CYCLES[CW-1:0];
      else if (blinking)
        blink_cnt_r <= blink_cnt_r - {{CW-1{1'b0}}, 1'b1};
      if (half_cnt_r == {CW{1'b0}})
      begin
        half_cnt_r <= HALF_CYCLES[CW-1:0] - {{CW-1{1'b0}}, 1'b1};
        blink_ph_r <= ~blink_ph_r;
      end
      else
        half_cnt_r <= half_cnt_r - {{CW-1{1'b0}}, 1'b1};
    end
  end

  // outputs, all registered from the next mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_disable_flag     <= 1'b1;
      executing_lamp          <= 1'b0;
      halted_lamp             <= 1'b1;
      restart_startup_routine <= 1'b0;
      cold_start_routine      <= 1'b0;
      cyclic_main_routine     <= 1'b0;
      timers_enable           <= 1'b0;
      image_refresh           <= 1'b0;
    end
    else
    begin
      // outputs only enabled in run
      output_disable_flag <= (mode_nxt != `MODE_RUN);
      // timers stop in stop and hold; their values are kept, not cleared
      timers_enable <= (mode_nxt == `MODE_RUN);
      image_refresh <= (mode_nxt == `MODE_RUN) & cycle_end;
      // the main routine runs in run and for one step in hold; stop suppresses it
      cyclic_main_routine <= (mode_nxt == `MODE_RUN) |
                             ((mode_r == `MODE_HOLD) & step_r);
      // start-up routine runs with no cycle supervision applied
      restart_startup_routine <= (mode_nxt == `MODE_STARTUP) &
        ~(cold_path_r | (mode_r == `MODE_STOP & wdog_lock_r));
      cold_start_routine <= (mode_nxt == `MODE_STARTUP) &
        (cold_path_r | (mode_r == `MODE_STOP & wdog_lock_r));
      case (mode_nxt)
        `MODE_RUN:
        begin
          executing_lamp <= blinking ? blink_ph_r : 1'b1;
          halted_lamp    <= 1'b0;
        end
        `MODE_HOLD:
        begin
          executing_lamp <= blink_ph_r;
          halted_lamp    <= 1'b1;
        end
        `MODE_STARTUP:
        begin
          executing_lamp <= blink_ph_r;
          halted_lamp    <= 1'b1;
        end
        default:
        begin
          executing_lamp <= blinking & blink_ph_r;
          halted_lamp    <= 1'b1;
        end
      endcase
    end
  end

  // apb read mux; unmapped addresses flag pslverr
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL:   rd_mux = 32'h0000_0000;
      `ADDR_STATUS: rd_mux = {25'h0000000, step_refused_r, bp_count,
                              wdog_lock_r, output_disable_flag, mode_r};
      `ADDR_ID:     rd_mux = ID_VALUE;
      default:
      begin
        // slot addresses are distinct, so at most one entry matches
        for (k = 0; k < NUM_BP; k = k + 1)
          if (bp_sel[k])
            rd_mux = {bp_act[k], 15'h0000,
                      bp_all[k*`BP_WIDTH +: `BP_ADDR_MSB+1]};
      end
    endcase
  end

  wire mapped = (paddr == `ADDR_CTRL) | (paddr == `ADDR_STATUS) |
                (paddr == `ADDR_ID) |
                (paddr >= `ADDR_BP_BASE && paddr <= `ADDR_BP_LAST &&
                 paddr[1:0] == 2'h0);

  // one wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= mapped ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// *** src/opmode_consts.vh ***
// constants for the operating-mode controller: mode codes, register map,
// field positions and timing figures
// assumes a 20 MHz APB clock
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

`define MODE_STOP        2'h0
`define MODE_STARTUP     2'h1
`define MODE_RUN         2'h2
`define MODE_HOLD        2'h3

`define ADDR_CTRL        12'h000
`define ADDR_STATUS      12'h004
`define ADDR_BP_BASE     12'h008
`define ADDR_BP_LAST     12'h010
`define ADDR_ID          12'h014

`define CTRL_RUN_REQ     0
`define CTRL_STOP_REQ    1
`define CTRL_STEP_REQ    2
`define CTRL_RESUME_REQ  3
`define CTRL_STARTUP_DONE 4
`define CTRL_WDOG_ERR    5
`define CTRL_CSR_PRESENT 6
`define CTRL_OVERALL_RST 7
`define CTRL_RELOAD      8
`define CTRL_BP_HIT      9

`define BP_VALID_BIT     31
`define BP_ADDR_MSB      15
`define BP_WIDTH         17
`define BP_VALID_POS     16
`define BP_STRIDE        4
`define STEP_MAX_BP      2'h2

`define CLK_HZ           20000000
`define BLINK_MIN_S      3
`define BLINK_HALF_MS    250

`endif

// *** tb/opmode_props.sv ***
// port assertions for the operating-mode controller
// assumes one clock domain; bound into every opmode_ctrl
`timescale 1ns/100ps
module opmode_props (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       cycle_end,
  input wire [1:0] mode_r,
  input wire       output_disable_flag,
  input wire       halted_lamp,
  input wire       restart_startup_routine,
  input wire       cold_start_routine,
  input wire       cyclic_main_routine,
  input wire       timers_enable,
  input wire       image_refresh
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  stop_outputs_a: assert property (mode_r == 2'h0 |->
    output_disable_flag && halted_lamp) else $error("stop outputs");
  stop_idle_a: assert property (mode_r == 2'h0 |->
    !cyclic_main_routine && !restart_startup_routine
    && !cold_start_routine) else $error("program runs in stop");
  startup_outputs_a: assert property (mode_r == 2'h1 |->
    output_disable_flag && halted_lamp) else $error("start-up outputs");
  run_outputs_a: assert property (mode_r == 2'h2 |->
    !output_disable_flag && !halted_lamp) else $error("run outputs");
  hold_outputs_a: assert property (mode_r == 2'h3 |->
    output_disable_flag && halted_lamp) else $error("hold outputs");
  hold_frozen_a: assert property (mode_r == 2'h3 |->
    !timers_enable) else $error("timers run in hold");
  refresh_cause_a: assert property (image_refresh |->
    $past(cycle_end) && mode_r == 2'h2) else $error("refresh");
  stop_exit_a: assert property ($past(mode_r) == 2'h0 &&
    mode_r != 2'h0 |-> mode_r == 2'h1) else $error("stop exit");
  apb_answer_a: assert property (psel && !penable |->
    ##2 pready) else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
endmodule
bind opmode_ctrl opmode_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .cycle_end(cycle_end), .mode_r(mode_r),
  .output_disable_flag(output_disable_flag),
  .halted_lamp(halted_lamp),
  .restart_startup_routine(restart_startup_routine),
  .cold_start_routine(cold_start_routine),
  .cyclic_main_routine(cyclic_main_routine),
  .timers_enable(timers_enable), .image_refresh(image_refresh));

// *** tb/exec_model.sv ***
// execution engine model: walks statement addresses 0..15
// assumes run_i high while the main routine may execute
`timescale 1ns/100ps
module exec_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        run_i,
  output reg  [15:0] prog_addr,
  output reg         cycle_end
);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prog_addr <= 16'h0000;
      cycle_end <= 1'b0;
    end
    else
    begin
      // address stands still when halted, so a hit stays visible
      if (run_i)
        prog_addr <= (prog_addr + 16'h0001) & 16'h000f;
      cycle_end <= run_i && prog_addr == 16'h000f;
    end
endmodule

// *** tb/cpu_operating_mode_control_bench.sv ***
// self-checking bench for the operating-mode controller
// assumes opmode_ctrl with shortened blink counts
`timescale 1ns/100ps
`include "opmode_consts.vh"
module cpu_operating_mode_control_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, cycle_end, odf, mode_lamp;
  wire [15:0] prog_addr;
  wire [1:0] mode_r;
  wire hl, rsr, csr, cmr, ten, irf;
  reg [31:0] q;
  reg se;
  reg [15:0] ba;
  reg [1:0] seen;
  integer n_fail = 0;
  integer checks = 0;
  integer i;
  always #25 pclk = ~pclk;
  opmode_ctrl #(.BLINK_CYCLES(40), .HALF_CYCLES(4),
    .ID_VALUE(32'h0000_1234)) u_opmode_ctrl ( // id is arbitrary
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .cycle_end(cycle_end), .mode_r(mode_r), .output_disable_flag(odf),
    .executing_lamp(mode_lamp), .halted_lamp(hl),
    .restart_startup_routine(rsr), .cold_start_routine(csr),
    .cyclic_main_routine(cmr), .timers_enable(ten),
    .image_refresh(irf));
  exec_model u_exec_model (.pclk(pclk), .presetn(presetn),
    .run_i(cmr), .prog_addr(prog_addr), .cycle_end(cycle_end));
  task chk(input [31:0] s, input [31:0] e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  end
  endtask
  function [6:0] status_exp(input refused, input [1:0] nbp, input lock,
    input odf_e, input [1:0] m);
    status_exp = {refused, nbp, lock, odf_e, m};
  endfunction
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k = k + 1;
    end
    if (pready !== 1'b1)
      n_fail = n_fail + 1;
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task cmd(input [31:0] d);
    apb(1'b1, `ADDR_CTRL, d);
  endtask
  task mode_is(input [1:0] m);
  begin
    @(posedge pclk);
    #1;
    chk(mode_r, m);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    #250000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial
  begin
    q = $urandom(32'h84b232b3);
    repeat (16) @(posedge pclk);
    chk({mode_r, odf, hl}, 4'h3);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_ID, 32'h0);
    chk(q, 32'h0000_1234);
    apb(1'b0, 12'h020, 32'h0);
    chk(se, 1'b1);
    cmd(32'h1 << `CTRL_RUN_REQ);
    mode_is(`MODE_STARTUP);
    chk(rsr, 1'b1);
    cmd(32'h1 << `CTRL_STARTUP_DONE);
    mode_is(`MODE_RUN);
    ba = $urandom % 16;
    apb(1'b1, `ADDR_BP_BASE, 32'h8000_0000 | ba);
    apb(1'b0, `ADDR_BP_BASE, 32'h0);
    chk(q, 32'h8000_0000 | ba);
    for (i = 0; i < 40 && mode_r !== `MODE_HOLD; i = i + 1)
      @(posedge pclk);
    chk(mode_r, `MODE_HOLD);
    seen = 2'h0;
    for (i = 0; i < 10; i = i + 1)
    begin
      @(posedge pclk);
      seen = seen | (mode_lamp ? 2'h2 : 2'h1);
    end
    chk(seen, 2'h3);
    chk(hl, 1'b1);
    for (i = 1; i < 3; i = i + 1)
      apb(1'b1, `ADDR_BP_BASE + 4 * i, 32'h8000_0000 | ((ba + i) % 16));
    cmd(32'h1 << `CTRL_STEP_REQ);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(q[6:0], status_exp(1'b1, 2'h3, 1'b0, 1'b1, `MODE_HOLD));
    cmd(32'h1 << `CTRL_STOP_REQ);
    mode_is(`MODE_STOP);
    for (i = 0; i < 3; i = i + 1)
      apb(1'b1, `ADDR_BP_BASE + 4 * i, $urandom & 32'h0000_ffff);
    cmd(32'h1 << `CTRL_RUN_REQ);
    cmd(32'h1 << `CTRL_STARTUP_DONE);
    cmd(32'h1 << `CTRL_WDOG_ERR);
    mode_is(`MODE_STOP);
    cmd(32'h1 << `CTRL_RUN_REQ);
    mode_is(`MODE_STOP);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(q[3], 1'b1);
    cmd(32'h41);
    mode_is(`MODE_STARTUP);
    chk(csr, 1'b1);
    cmd(32'h1 << `CTRL_STARTUP_DONE);
    cmd(32'h1 << `CTRL_WDOG_ERR);
    cmd(32'h1 << `CTRL_OVERALL_RST);
    cmd(32'h1 << `CTRL_RUN_REQ);
    mode_is(`MODE_STARTUP);
    report_and_stop;
  end
endmodule
